// file: common/sfce_map.svh
/*
 * sfce_map.svh: offsets, field positions, reset values, opcodes and timing counts of the flash command engine.
 * Assumes a single 250 MHz system clock; included by bare name.
 */
`ifndef SFCE_MAP_SVH
`define SFCE_MAP_SVH
`define SFCE_CLK_MHZ 250
`define SFCE_OPC_READ 8'h10
`define SFCE_OPC_WRITE 8'h20
`define SFCE_OPC_ERASE 8'h30
`define SFCE_OPC_BITS 4'h7
`define SFCE_WORD_BITS 4'hf
`define SFCE_WORD_AW 12
`define SFCE_WORD_DW 16
`define SFCE_ADDR_MSB 12
`define SFCE_BLK_LSB 8
`define SFCE_BLK_OFS_BITS 7
`define SFCE_BLK_OFS_LAST 7'h7f
`define SFCE_ERASED 16'hffff
`define SFCE_FIFO_DEPTH 8
`define SFCE_PROG_TIME_NS 20000
`define SFCE_ERASE_TIME_NS 1000000
`define SFCE_PROG_CYCLES ((`SFCE_PROG_TIME_NS * `SFCE_CLK_MHZ + 999) / 1000)
`define SFCE_ERASE_CYCLES ((`SFCE_ERASE_TIME_NS * `SFCE_CLK_MHZ + 999) / 1000)
`endif

// file: common/sfce_mem_if.sv
/*
 * sfce_mem_if: word port between the command engine and its flash array model.
 * Assumes both ends on the same clock.
 */
`timescale 1ns/10ps
interface sfce_mem_if #(parameter int AW = 12, parameter int DW = 16);
    logic wen;
    logic ren;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    modport ctrl (output wen, output ren, output addr, output wdata, input rdata);
    modport mem (input wen, input ren, input addr, input wdata, output rdata);
endinterface

// file: common/sfce_pkg.sv
/*
 * sfce_pkg: types shared by the flash command engine files.
 * Assumes nothing of its surroundings.
 */
package sfce_pkg;
    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_OPC = 6'h02,
        S_ADDR = 6'h04,
        S_READ = 6'h08,
        S_WRITE = 6'h10,
        S_HOLD = 6'h20
    } sfce_frame_e;
    typedef enum logic [3:0] {
        E_IDLE = 4'h1,
        E_PROG = 4'h2,
        E_ERASE = 4'h4,
        E_WAIT = 4'h8
    } sfce_eng_e;
    typedef enum logic [2:0] {
        C_READ = 3'h1,
        C_WRITE = 3'h2,
        C_ERASE = 3'h4
    } sfce_cmd_e;
    typedef logic [15:0] sfce_word_t;
endpackage

// file: hdl/sfce_engine.sv
/*
 * sfce_engine: serial command engine for an 8KB x16 embedded flash (read stream, word program, block erase).
 * Assumes SPI mode 0 pins from another domain, half period of the serial clock at least 8 system cycles,
 * regulator_on and int_enable and flash_flag_clear from logic on sys_clk.
 */
`timescale 1ns/10ps
`include "sfce_map.svh"
module sfce_engine #(
    parameter logic [7:0] OPC_READ = `SFCE_OPC_READ,
    parameter logic [7:0] OPC_WRITE = `SFCE_OPC_WRITE,
    parameter logic [7:0] OPC_ERASE = `SFCE_OPC_ERASE,
    parameter int unsigned PROG_CYCLES = `SFCE_PROG_CYCLES,
    parameter int unsigned ERASE_CYCLES = `SFCE_ERASE_CYCLES,
    parameter int FIFO_DEPTH = `SFCE_FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic spi_sclk,
    input wire logic spi_ce_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe_n,
    input wire logic regulator_on,
    input wire logic int_enable,
    input wire logic flash_flag_clear,
    output logic flash_flag,
    output logic int_n,
    output logic busy
);
    logic [2:0] sclk_s_q;
    logic [2:0] ce_s_q;
    logic [2:0] mosi_s_q;
    logic sclk_f_q;
    logic sclk_prev_q;
    logic ce_n_f_q;
    logic ce_prev_q;
    logic mosi_f_q;
    logic sclk_rise;
    logic sclk_fall;
    logic ce_rise;
    logic ce_fall;
    sfce_pkg::sfce_frame_e state_q;
    sfce_pkg::sfce_cmd_e cmd_q;
    sfce_pkg::sfce_eng_e eng_q;
    logic [3:0] cnt_q;
    sfce_pkg::sfce_word_t sr_q;
    sfce_pkg::sfce_word_t nxt;
    sfce_pkg::sfce_word_t hold_q;
    logic hold_vld_q;
    logic [`SFCE_WORD_AW-1:0] wr_addr_q;
    logic [`SFCE_WORD_AW-1:0] pf_addr_q;
    logic [`SFCE_WORD_AW-1:0] e_addr_q;
    sfce_pkg::sfce_word_t e_data_q;
    logic prog_req_q;
    logic erase_req_q;
    logic done_q;
    logic [31:0] timer_q;
    logic pend_q;
    logic pf_ren;
    logic [3:0] tx_cnt_q;
    sfce_pkg::sfce_word_t tx_sr_q;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    logic fifo_flush;
    sfce_pkg::sfce_word_t fifo_out;
    logic flag_d;
    logic miso_q;
    logic miso_oe_n_q;
    logic flag_q;
    logic int_n_q;
    logic busy_q;

    sfce_mem_if #(.AW(`SFCE_WORD_AW), .DW(`SFCE_WORD_DW)) mem_bus ();

    // three stages; second and third must agree before a level is taken
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sclk_s_q <= 3'h0;
            ce_s_q <= 3'h7;
            mosi_s_q <= 3'h0;
        end else begin
            sclk_s_q <= {sclk_s_q[1:0], spi_sclk};
            ce_s_q <= {ce_s_q[1:0], spi_ce_n};
            mosi_s_q <= {mosi_s_q[1:0], spi_mosi};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sclk_f_q <= 1'b0;
            ce_n_f_q <= 1'b1;
            mosi_f_q <= 1'b0;
            sclk_prev_q <= 1'b0;
            ce_prev_q <= 1'b1;
        end else begin
            if (sclk_s_q[2] == sclk_s_q[1]) begin
                sclk_f_q <= sclk_s_q[2];
            end
            if (ce_s_q[2] == ce_s_q[1]) begin
                ce_n_f_q <= ce_s_q[2];
            end
            if (mosi_s_q[2] == mosi_s_q[1]) begin
                mosi_f_q <= mosi_s_q[2];
            end
            sclk_prev_q <= sclk_f_q;
            ce_prev_q <= ce_n_f_q;
        end
    end

    assign sclk_rise = sclk_f_q && !sclk_prev_q && !ce_n_f_q;
    assign sclk_fall = !sclk_f_q && sclk_prev_q && !ce_n_f_q;
    assign ce_rise = ce_n_f_q && !ce_prev_q;
    assign ce_fall = !ce_n_f_q && ce_prev_q;
    assign nxt = {sr_q[14:0], mosi_f_q};

    // frame decoder: opcode, address word, then data
    always_ff @(posedge sys_clk) begin
        if (srst || ce_n_f_q) begin
            state_q <= sfce_pkg::S_IDLE;
            cnt_q <= 4'h0;
        end else begin
            case (state_q)
                sfce_pkg::S_IDLE: begin
                    if (ce_fall) begin
                        state_q <= sfce_pkg::S_OPC;
                        cnt_q <= 4'h0;
                    end
                end
                sfce_pkg::S_OPC: begin
                    if (sclk_rise) begin
                        cnt_q <= cnt_q + 4'h1;
                        if (cnt_q == `SFCE_OPC_BITS) begin
                            cnt_q <= 4'h0;
                            // busy engine or regulator off: frame is ignored
                            if (!regulator_on || eng_q != sfce_pkg::E_IDLE) begin
                                state_q <= sfce_pkg::S_HOLD;
                            end else if (nxt[7:0] == OPC_READ || nxt[7:0] == OPC_WRITE ||
                                         nxt[7:0] == OPC_ERASE) begin
                                state_q <= sfce_pkg::S_ADDR;
                            end else begin
                                state_q <= sfce_pkg::S_HOLD;
                            end
                        end
                    end
                end
                sfce_pkg::S_ADDR: begin
                    if (sclk_rise) begin
                        cnt_q <= cnt_q + 4'h1;
                        if (cnt_q == `SFCE_WORD_BITS) begin
                            if (cmd_q == sfce_pkg::C_READ) begin
                                state_q <= sfce_pkg::S_READ;
                            end else if (cmd_q == sfce_pkg::C_WRITE) begin
                                state_q <= sfce_pkg::S_WRITE;
                            end else begin
                                state_q <= sfce_pkg::S_HOLD;
                            end
                        end
                    end
                end
                sfce_pkg::S_WRITE: begin
                    if (sclk_rise) begin
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
                default: begin
                    state_q <= state_q;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cmd_q <= sfce_pkg::C_READ;
        end else if (state_q == sfce_pkg::S_OPC && sclk_rise && cnt_q == `SFCE_OPC_BITS) begin
            // a refused frame must not leave an erase armed for chip-select release
            if (!regulator_on || eng_q != sfce_pkg::E_IDLE) begin
                cmd_q <= sfce_pkg::C_READ;
            end else if (nxt[7:0] == OPC_WRITE) begin
                cmd_q <= sfce_pkg::C_WRITE;
            end else if (nxt[7:0] == OPC_ERASE) begin
                cmd_q <= sfce_pkg::C_ERASE;
            end else begin
                cmd_q <= sfce_pkg::C_READ;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sr_q <= 16'h0000;
        end else if (sclk_rise) begin
            sr_q <= nxt;
        end
    end

    // address word: byte address bits 12..1 pick the word; bit 0 ignored
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wr_addr_q <= 12'h000;
        end else if (state_q == sfce_pkg::S_ADDR && sclk_rise && cnt_q == `SFCE_WORD_BITS) begin
            wr_addr_q <= nxt[`SFCE_ADDR_MSB:1];
        end
    end

    // single holding register, overwritten by each whole word
    always_ff @(posedge sys_clk) begin
        if (srst || state_q == sfce_pkg::S_IDLE) begin
            hold_q <= 16'hffff;
            hold_vld_q <= 1'b0;
        end else if (state_q == sfce_pkg::S_WRITE && sclk_rise && cnt_q == `SFCE_WORD_BITS) begin
            hold_q <= nxt;
            hold_vld_q <= 1'b1;
        end
    end

    // commands start at chip-select release, never mid-frame
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            prog_req_q <= 1'b0;
            erase_req_q <= 1'b0;
        end else begin
            prog_req_q <= ce_rise && state_q == sfce_pkg::S_WRITE && hold_vld_q;
            erase_req_q <= ce_rise && state_q == sfce_pkg::S_HOLD && cmd_q == sfce_pkg::C_ERASE &&
                           cnt_q == 4'h0 && eng_q == sfce_pkg::E_IDLE && regulator_on;
        end
    end

    // prefetch: one read in flight, stalls on a full fifo
    assign fifo_flush = (state_q != sfce_pkg::S_READ);
    assign pf_ren = !fifo_flush && !pend_q && fifo_in_ready;

    always_ff @(posedge sys_clk) begin
        if (srst || fifo_flush) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= pf_ren;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pf_addr_q <= 12'h000;
        end else if (state_q == sfce_pkg::S_ADDR && sclk_rise && cnt_q == `SFCE_WORD_BITS) begin
            pf_addr_q <= nxt[`SFCE_ADDR_MSB:1];
        end else if (pf_ren) begin
            pf_addr_q <= pf_addr_q + 12'h001;
        end
    end

    assign fifo_pop = sclk_fall && state_q == sfce_pkg::S_READ && tx_cnt_q == 4'h0 && fifo_out_valid;

    // shift out on falling serial clock, msb first
    always_ff @(posedge sys_clk) begin
        if (srst || state_q != sfce_pkg::S_READ) begin
            tx_cnt_q <= 4'h0;
            tx_sr_q <= 16'h0000;
            miso_q <= 1'b0;
        end else if (sclk_fall) begin
            tx_cnt_q <= tx_cnt_q + 4'h1;
            if (tx_cnt_q == 4'h0) begin
                miso_q <= fifo_out[15];
                tx_sr_q <= {fifo_out[14:0], 1'b0};
            end else begin
                miso_q <= tx_sr_q[15];
                tx_sr_q <= {tx_sr_q[14:0], 1'b0};
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            miso_oe_n_q <= 1'b1;
        end else begin
            miso_oe_n_q <= ce_n_f_q;
        end
    end

    // program and erase sequencer; busy blocks new frames
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            eng_q <= sfce_pkg::E_IDLE;
            e_addr_q <= 12'h000;
            e_data_q <= 16'hffff;
            timer_q <= 32'h0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (eng_q)
                sfce_pkg::E_IDLE: begin
                    if (prog_req_q) begin
                        eng_q <= sfce_pkg::E_PROG;
                        e_addr_q <= wr_addr_q;
                        e_data_q <= hold_q;
                    end else if (erase_req_q) begin
                        eng_q <= sfce_pkg::E_ERASE;
                        e_addr_q <= {wr_addr_q[`SFCE_WORD_AW-1:`SFCE_BLK_OFS_BITS], 7'h00};
                    end
                end
                sfce_pkg::E_PROG: begin
                    eng_q <= sfce_pkg::E_WAIT;
                    timer_q <= 32'(PROG_CYCLES - 1);
                end
                sfce_pkg::E_ERASE: begin
                    e_addr_q <= e_addr_q + 12'h001;
                    if (e_addr_q[`SFCE_BLK_OFS_BITS-1:0] == `SFCE_BLK_OFS_LAST) begin
                        eng_q <= sfce_pkg::E_WAIT;
                        timer_q <= 32'(ERASE_CYCLES - 1);
                    end
                end
                sfce_pkg::E_WAIT: begin
                    if (timer_q == 32'h0) begin
                        eng_q <= sfce_pkg::E_IDLE;
                        done_q <= 1'b1;
                    end else begin
                        timer_q <= timer_q - 32'h1;
                    end
                end
                default: begin
                    eng_q <= sfce_pkg::E_IDLE;
                end
            endcase
        end
    end

    assign mem_bus.wen = (eng_q == sfce_pkg::E_PROG) || (eng_q == sfce_pkg::E_ERASE);
    assign mem_bus.ren = pf_ren;
    assign mem_bus.addr = mem_bus.wen ? e_addr_q : pf_addr_q;
    assign mem_bus.wdata = (eng_q == sfce_pkg::E_ERASE) ? `SFCE_ERASED : e_data_q;

    // completion wins over a clear in the same cycle
    assign flag_d = done_q || (flag_q && !flash_flag_clear);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            flag_q <= 1'b0;
            int_n_q <= 1'b1;
            busy_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
            int_n_q <= !(flag_d && int_enable);
            busy_q <= (eng_q != sfce_pkg::E_IDLE) || prog_req_q || erase_req_q;
        end
    end

    sfce_fifo #(.W(`SFCE_WORD_DW), .D(FIFO_DEPTH)) u_fifo (
        .sys_clk(sys_clk),
        .srst(srst),
        .flush(fifo_flush),
        .in_valid(pend_q),
        .in_ready(fifo_in_ready),
        .in_data(mem_bus.rdata),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out)
    );

    sfce_flash_mem #(.AW(`SFCE_WORD_AW), .DW(`SFCE_WORD_DW)) u_mem (
        .sys_clk(sys_clk),
        .port(mem_bus.mem)
    );

    assign spi_miso = miso_q;
    assign spi_miso_oe_n = miso_oe_n_q;
    assign flash_flag = flag_q;
    assign int_n = int_n_q;
    assign busy = busy_q;
endmodule // sfce_engine

// file: hdl/sfce_fifo.sv
/*
 * sfce_fifo: small synchronous valid/ready FIFO with flush.
 * Assumes one clock; flush empties it in one cycle.
 */
`timescale 1ns/10ps
module sfce_fifo #(
    parameter int W = 16,
    parameter int D = 8
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int PW = $clog2(D);
    logic [W-1:0] buf_q [0:D-1];
    logic [PW:0] wr_q;
    logic [PW:0] rd_q;
    logic push;
    logic pop;

    assign in_ready = (wr_q[PW-1:0] != rd_q[PW-1:0]) || (wr_q[PW] == rd_q[PW]);
    assign out_valid = (wr_q != rd_q);
    assign out_data = buf_q[rd_q[PW-1:0]];
    assign push = in_valid && in_ready && !flush;
    assign pop = out_valid && out_ready && !flush;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            buf_q[wr_q[PW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst || flush) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule // sfce_fifo

// file: hdl/sfce_flash_mem.sv
/*
 * sfce_flash_mem: word-wide flash array, registered read data.
 * Assumes one access per cycle; writes take priority in the controller.
 */
`timescale 1ns/10ps
`include "sfce_map.svh"
module sfce_flash_mem #(
    parameter int AW = 12,
    parameter int DW = 16
) (
    input wire logic sys_clk,
    sfce_mem_if.mem port
);
    logic [DW-1:0] arr [0:(1<<AW)-1];
    logic [DW-1:0] rdata_q;

    // leaves production fully erased
    initial begin
        for (int i = 0; i < (1 << AW); i++) begin
            arr[i] = DW'(`SFCE_ERASED);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (port.wen) begin
            arr[port.addr] <= port.wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (port.ren) begin
            rdata_q <= arr[port.addr];
        end
    end

    assign port.rdata = rdata_q;
endmodule // sfce_flash_mem

// file: test/sfce_engine_sva.sv
/*
 * sfce_engine_sva: pin-level timing checks of the flash command engine.
 * Assumes it is bound into sfce_engine and sees only its ports.
 */
`timescale 1ns/10ps
module sfce_engine_sva #(
    parameter int unsigned PROG_CYCLES = 10,
    parameter int unsigned ERASE_CYCLES = 20
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic spi_ce_n,
    input wire logic spi_miso,
    input wire logic spi_miso_oe_n,
    input wire logic int_enable,
    input wire logic flash_flag_clear,
    input wire logic flash_flag,
    input wire logic int_n,
    input wire logic busy
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    int unsigned busy_cnt_q;
    always_ff @(posedge sys_clk) begin
        if (srst || !busy)
            busy_cnt_q <= 32'h0;
        else
            busy_cnt_q <= busy_cnt_q + 32'h1;
    end
    sequence ce_idle_s; spi_ce_n [*8]; endsequence
    sequence ce_sel_s; !spi_ce_n [*8]; endsequence
    // a reset edge also drops busy, so that fall is not an operation end
    sequence done_s; $fell(busy) && !$past(srst); endsequence
    AST_IDLE_PINS: assert property (ce_idle_s |-> spi_miso_oe_n && !spi_miso)
        else $error("miso driven outside a frame");
    AST_SEL_DRIVE: assert property (ce_sel_s |-> !spi_miso_oe_n)
        else $error("miso not driven inside a frame");
    AST_BUSY_AFTER_CE: assert property ($rose(busy) |-> spi_ce_n)
        else $error("operation started with chip select low");
    AST_BUSY_LEN: assert property (done_s |-> busy_cnt_q >= PROG_CYCLES && busy_cnt_q <= ERASE_CYCLES + 200)
        else $error("operation length out of range");
    AST_DONE_FLAG: assert property (done_s |-> ##[0:2] flash_flag)
        else $error("flag missing after operation");
    AST_INT_LOW: assert property (!int_n |-> flash_flag)
        else $error("interrupt without flag");
    AST_INT_ASSERT: assert property (flash_flag && $past(int_enable) |-> !int_n)
        else $error("enabled interrupt not asserted");
    AST_FLAG_HOLD: assert property (flash_flag && !flash_flag_clear |=> flash_flag)
        else $error("flag lost without clear");
    AST_FLAG_CLR: assert property (flash_flag_clear && !busy && !$past(busy) |=> !flash_flag)
        else $error("flag not cleared");
    AST_FLAG_CAUSE: assert property ($rose(flash_flag) |-> $past(busy) || $past(busy, 2))
        else $error("flag set without operation");
endmodule // sfce_engine_sva
bind sfce_engine sfce_engine_sva #(
    .PROG_CYCLES(PROG_CYCLES),
    .ERASE_CYCLES(ERASE_CYCLES)
) u_sva (
    .sys_clk(sys_clk), .srst(srst), .spi_ce_n(spi_ce_n), .spi_miso(spi_miso),
    .spi_miso_oe_n(spi_miso_oe_n), .int_enable(int_enable), .flash_flag_clear(flash_flag_clear),
    .flash_flag(flash_flag), .int_n(int_n), .busy(busy)
);

// file: test/sfce_engine_tb_top.sv
/*
 * sfce_engine_tb_top: self-checking bench of the flash command engine.
 * Assumes the host model drives the serial pins; short program and erase counts.
 */
`timescale 1ns/10ps
`include "sfce_map.svh"
module sfce_engine_tb_top;
    localparam int PROG = 10;
    localparam int ERASE = 20;
    typedef struct packed {
        logic [15:0] addr;
        logic [5:0] nbits;
        logic [47:0] data;
        logic ien;
        logic [15:0] exp;
    } sfce_row_s;
    sfce_row_s rows [0:6];
    logic sys_clk, srst, spi_sclk, spi_ce_n, spi_mosi, spi_miso, spi_miso_oe_n;
    logic regulator_on, int_enable, flash_flag_clear, flash_flag, int_n, busy;
    int num_errors = 0;
    int tests_run = 0;
    sfce_engine #(.PROG_CYCLES(PROG), .ERASE_CYCLES(ERASE)) dut (
        .sys_clk(sys_clk), .srst(srst), .spi_sclk(spi_sclk), .spi_ce_n(spi_ce_n),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n),
        .regulator_on(regulator_on), .int_enable(int_enable), .flash_flag_clear(flash_flag_clear),
        .flash_flag(flash_flag), .int_n(int_n), .busy(busy)
    );
    sfce_host_model host (
        .sys_clk(sys_clk), .spi_sclk(spi_sclk), .spi_ce_n(spi_ce_n),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso)
    );
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic test_done();
        if (num_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: pin %b expected %b", $time, got, exp);
        end
    endtask
    // no completion within the bound ends the run
    task automatic wait_flag();
        int n;
        n = 0;
        while (flash_flag !== 1'b1 && n < 2000) begin
            @(negedge sys_clk);
            n++;
        end
        if (flash_flag !== 1'b1) begin
            num_errors++;
            $display("ERROR %0t: completion flag timeout", $time);
            test_done();
        end
    endtask
    task automatic clear_flag();
        flash_flag_clear = 1'b1;
        @(negedge sys_clk);
        flash_flag_clear = 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask
    // every written word lies in a never-programmed, erased place
    initial begin
        rows[0] = '{16'h0010, 6'h10, 48'h1234, 1'b1, 16'h1234};
        rows[1] = '{16'h0020, 6'h20, 48'haaaa5555, 1'b0, 16'h5555};
        rows[2] = '{16'h0030, 6'h18, 48'hbeef12, 1'b1, 16'hbeef};
        rows[3] = '{16'h1ffe, 6'h10, 48'h0f0f, 1'b0, 16'h0f0f};
        rows[4] = '{16'h0000, 6'h10, 48'hc3c3, 1'b1, 16'hc3c3};
        rows[5] = '{16'h1efe, 6'h10, 48'h7777, 1'b0, 16'h7777};
        rows[6] = '{16'h1f00, 6'h10, 48'h5a5a, 1'b1, 16'h5a5a};
        srst = 1'b1;
        regulator_on = 1'b1;
        int_enable = 1'b0;
        flash_flag_clear = 1'b0;
        repeat (16) @(negedge sys_clk);
        srst = 1'b0;
        chk_bit(spi_miso, 1'b0);
        chk_bit(spi_miso_oe_n, 1'b1);
        chk_bit(flash_flag, 1'b0);
        chk_bit(int_n, 1'b1);
        chk_bit(busy, 1'b0);
        repeat (4) @(negedge sys_clk);
        for (int r = 0; r < 7; r++) begin
            int_enable = rows[r].ien;
            host.frame(`SFCE_OPC_WRITE, rows[r].addr, rows[r].nbits, rows[r].data, 0);
            wait_flag();
            chk_bit(int_n, ~rows[r].ien);
            clear_flag();
            chk_bit(flash_flag, 1'b0);
            host.frame(`SFCE_OPC_READ, rows[r].addr, 0, 48'h0, 1);
            chk_word(host.rd_q[0], rows[r].exp);
        end
        host.frame(`SFCE_OPC_READ, 16'hfffe, 0, 48'h0, 3);
        chk_word(host.rd_q[0], 16'h0f0f);
        chk_word(host.rd_q[1], 16'hc3c3);
        chk_word(host.rd_q[2], 16'hffff);
        int_enable = 1'b1;
        host.frame(`SFCE_OPC_ERASE, 16'h1f80, 0, 48'h0, 0);
        wait_flag();
        chk_bit(int_n, 1'b0);
        clear_flag();
        host.frame(`SFCE_OPC_READ, 16'h1efe, 0, 48'h0, 2);
        chk_word(host.rd_q[0], 16'h7777);
        chk_word(host.rd_q[1], 16'hffff);
        host.frame(`SFCE_OPC_READ, 16'h1ffe, 0, 48'h0, 2);
        chk_word(host.rd_q[0], 16'hffff);
        chk_word(host.rd_q[1], 16'hc3c3);
        regulator_on = 1'b0;
        host.frame(`SFCE_OPC_WRITE, 16'h0050, 16, 48'h1111, 0);
        repeat (100) @(negedge sys_clk);
        chk_bit(busy, 1'b0);
        chk_bit(flash_flag, 1'b0);
        regulator_on = 1'b1;
        host.frame(`SFCE_OPC_READ, 16'h0050, 0, 48'h0, 1);
        chk_word(host.rd_q[0], 16'hffff);
        // reset while a program runs: outputs return to idle, array keeps its words
        host.frame(`SFCE_OPC_WRITE, 16'h0060, 16, 48'h2222, 0);
        chk_bit(busy, 1'b1);
        srst = 1'b1;
        repeat (4) @(negedge sys_clk);
        srst = 1'b0;
        chk_bit(busy, 1'b0);
        chk_bit(flash_flag, 1'b0);
        chk_bit(int_n, 1'b1);
        chk_bit(spi_miso_oe_n, 1'b1);
        repeat (4) @(negedge sys_clk);
        host.frame(`SFCE_OPC_READ, 16'h0010, 0, 48'h0, 1);
        chk_word(host.rd_q[0], 16'h1234);
        test_done();
    end
endmodule // sfce_engine_tb_top

// file: test/sfce_host_model.sv
/*
 * sfce_host_model: serial master clocking frames into the engine, capturing read words.
 * Assumes the engine samples on rising sclk and shifts out on falling sclk.
 */
`timescale 1ns/10ps
module sfce_host_model #(
    parameter int HALF = 10
) (
    input wire logic sys_clk,
    output logic spi_sclk,
    output logic spi_ce_n,
    output logic spi_mosi,
    input wire logic spi_miso
);
    logic [15:0] rd_q [0:3];
    initial begin
        spi_sclk = 1'b0;
        spi_ce_n = 1'b1;
        spi_mosi = 1'b0;
    end
    task automatic half_wait();
        repeat (HALF) @(negedge sys_clk);
    endtask
    // clock stands low between frames; opcode comes from the caller
    task automatic frame(input logic [7:0] opc, input logic [15:0] addr, input int nbits,
                         input logic [47:0] data, input int nrd);
        logic [23:0] hdr;
        int k;
        hdr = {opc, addr};
        spi_ce_n = 1'b0;
        half_wait();
        for (int i = 0; i < 24 + nbits + 16 * nrd; i++) begin
            if (i < 24)
                spi_mosi = hdr[23 - i];
            else if (i < 24 + nbits)
                spi_mosi = data[nbits - 1 - (i - 24)];
            else
                spi_mosi = ~spi_mosi;
            half_wait();
            if (i >= 24 + nbits) begin
                k = (i - 24 - nbits) / 16;
                rd_q[k] = {rd_q[k][14:0], spi_miso};
            end
            spi_sclk = 1'b1;
            half_wait();
            spi_sclk = 1'b0;
        end
        half_wait();
        spi_ce_n = 1'b1;
        spi_mosi = ~spi_mosi;
        repeat (12) @(negedge sys_clk);
    endtask
endmodule // sfce_host_model
